// [design/irq4_ctrl.sv]
// Level-4 interrupt controller with AXI4-Lite register access
// Behaviour
// - Trigger select 0 in dedicated mode: line low keeps level-1 request pending.
// - Trigger select 1: only a falling edge of the line makes it pending.
// - Level-1 acknowledge gets vector and acknowledge even after the line rises.
// - Vector is three programmed upper bits above five generated source bits.
// - Until upper bits are written, every vector returned is 0F.
// - Mode register bit 11 and bits 4 to 0 are reserved, no function.
// - A request from a source without events sets its bit in the 16-bit pending register.
// - Passing a vector clears that pending bit unless the source has events.
// - Writing one clears a pending bit of a source without events; zero leaves it; software cannot set.
// - Event sources stay pending while any unmasked event bit is set.
// - Level-4 acknowledge with nothing pending sets the error pending bit.
// - Reset clears pending, mask and in-service registers.
// - Mask zero blocks the request but the pending bit still sets.
// - Clearing mask withdraws request, pending kept; setting it restores request.
// - Error source cannot be masked; mask bit 0 has no meaning.
// - Masked at acknowledge: next unmasked source answers, else error code 00000.
// - Passing a source vector sets its in-service bit.
// - Writing one clears an in-service bit; handler must clear its own.
// - New source forwarded only if above highest set in-service bit.
// - Error vector sets no in-service bit; in-service bit 0 reads zero.
// - Low vector bits: 01111 highest source down to 00001, 00000 error.
// - Mode bit 15 selects dedicated request lines.
module irq4_ctrl #(
  parameter logic [15:0] HAS_EVENT = irq4_pkg::HAS_EVT_DEF
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RSTN,
  input  wire logic [irq4_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                        AWVALID,
  output logic                             AWREADY,
  input  wire logic [31:0]                 WDATA,
  input  wire logic [3:0]                  WSTRB,
  input  wire logic                        WVALID,
  output logic                             WREADY,
  output logic [1:0]                       BRESP,
  output logic                             BVALID,
  input  wire logic                        BREADY,
  input  wire logic [irq4_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                        ARVALID,
  output logic                             ARREADY,
  output logic [31:0]                      RDATA,
  output logic [1:0]                       RRESP,
  output logic                             RVALID,
  input  wire logic                        RREADY,
  input  wire logic [15:1]                 INTERNAL_LEVEL4_REQUEST,
  input  wire logic [15:1]                 EVENT_ACTIVE,
  input  wire logic                        REQUEST_LINE_LOW_N,
  input  wire logic                        ACK_LEVEL4,
  input  wire logic                        ACK_LEVEL1,
  output logic                             LEVEL4_REQ,
  output logic                             LEVEL1_REQ,
  output logic [7:0]                       VECTOR,
  output logic                             VECTOR_VALID
);

  // Highest set bit above bit 0; bit 0 never wins, so an empty set gives zero
  function automatic logic [3:0] top_idx(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [15:0]                 mode_reg;
  logic [15:0]                 mode_next;
  logic [15:0]                 pend_reg;
  logic [15:0]                 pend_next;
  logic [15:0]                 mask_reg;
  logic [15:0]                 mask_next;
  logic [15:0]                 insv_reg;
  logic [15:0]                 insv_next;
  logic                        vec_wr_reg;
  logic                        line_prev_reg;
  logic                        l1_pend_reg;
  logic                        l1_pend_next;
  logic                        aw_rdy_reg;
  logic                        w_rdy_reg;
  logic                        bvalid_reg;
  logic [1:0]                  bresp_reg;
  logic                        ar_rdy_reg;
  logic                        rvalid_reg;
  logic [31:0]                 rdata_reg;
  logic [1:0]                  rresp_reg;
  logic [irq4_pkg::ADDR_W-1:0] wa_reg;
  logic [15:0]                 wd_reg;
  logic [1:0]                  ws_reg;
  logic                        l4_req_reg;
  logic                        l1_req_reg;
  logic [7:0]                  vec_reg;
  logic                        vec_vld_reg;

  // Bus handshakes and register decode
  logic        aw_hs;
  logic        w_hs;
  logic        wr_fire;
  logic        b_hs;
  logic        ar_hs;
  logic        r_hs;
  logic [15:0] bmask;
  logic [15:0] wbits;
  logic        wr_mode;
  logic        wr_pend;
  logic        wr_mask;
  logic        wr_insv;
  logic        wr_hit;
  logic        rd_mode;
  logic        rd_pend;
  logic        rd_mask;
  logic        rd_insv;
  logic        rd_hit;
  logic [15:0] rd_val;

  assign aw_hs    = AWVALID & aw_rdy_reg;
  assign w_hs     = WVALID & w_rdy_reg;
  // Both halves held and no answer out yet: the write lands this cycle
  assign wr_fire  = ~aw_rdy_reg & ~w_rdy_reg & ~bvalid_reg;
  assign b_hs     = bvalid_reg & BREADY;
  assign ar_hs    = ARVALID & ar_rdy_reg;
  assign r_hs     = rvalid_reg & RREADY;
  // Only byte lanes 0 and 1 exist; the upper lanes are ignored
  assign bmask    = {{8{ws_reg[1]}}, {8{ws_reg[0]}}};
  assign wbits    = wd_reg & bmask;
  assign wr_mode  = wr_fire & (wa_reg == irq4_pkg::OFS_MODE);
  assign wr_pend  = wr_fire & (wa_reg == irq4_pkg::OFS_PEND);
  assign wr_mask  = wr_fire & (wa_reg == irq4_pkg::OFS_MASK);
  assign wr_insv  = wr_fire & (wa_reg == irq4_pkg::OFS_INSV);
  assign wr_hit   = wr_mode | wr_pend | wr_mask | wr_insv;
  assign rd_mode  = ARADDR == irq4_pkg::OFS_MODE;
  assign rd_pend  = ARADDR == irq4_pkg::OFS_PEND;
  assign rd_mask  = ARADDR == irq4_pkg::OFS_MASK;
  assign rd_insv  = ARADDR == irq4_pkg::OFS_INSV;
  assign rd_hit   = rd_mode | rd_pend | rd_mask | rd_insv;
  assign rd_val   = rd_mode ? mode_reg : rd_pend ? pend_reg : rd_mask ? mask_reg :
                    rd_insv ? insv_reg : irq4_pkg::RST16;

  // Priority and forwarding
  logic [15:0] mask_eff;
  logic [15:0] live;
  logic [3:0]  cand;
  logic [3:0]  insv_top;
  logic        fwd;
  logic [15:0] cand_oh;

  // Bit 0 is the error source: it never competes, whatever the mask holds
  assign mask_eff = {mask_reg[15:1], 1'b0};
  assign live     = pend_reg & mask_eff;
  assign cand     = top_idx(live);
  assign insv_top = top_idx(insv_reg);
  // Nesting: the candidate must outrank the highest in-service source
  assign fwd      = cand > insv_top;
  assign cand_oh  = 16'h0001 << cand;

  // Acknowledge effects
  logic        ack_src;
  logic        ack_err;
  logic [4:0]  code4;
  logic [15:0] ack_clr;
  logic [15:0] ack_set;
  logic [15:0] src_set;
  logic [15:0] evt_lvl;
  logic [15:0] pend_w1c;
  logic [15:0] insv_w1c;
  logic [2:0]  upper;
  logic        l1_int;

  // A source masked just before the acknowledge falls back to the next one or to error
  assign ack_src  = ACK_LEVEL4 & fwd;
  assign ack_err  = ACK_LEVEL4 & ~fwd;
  assign code4    = ack_src ? {1'b0, cand} : irq4_pkg::ERR_CODE;
  assign ack_clr  = ack_src ? (cand_oh & ~HAS_EVENT) : irq4_pkg::RST16;
  assign ack_set  = ack_src ? cand_oh : irq4_pkg::RST16;
  // Error acknowledge latches bit 0 just as a source request latches its own bit
  assign src_set  = {INTERNAL_LEVEL4_REQUEST, ack_err};
  assign evt_lvl  = {EVENT_ACTIVE, 1'b0};
  assign pend_w1c = wr_pend ? wbits : irq4_pkg::RST16;
  assign insv_w1c = wr_insv ? wbits : irq4_pkg::RST16;
  assign upper    = mode_reg[irq4_pkg::VEC_MSB:irq4_pkg::VEC_LSB];
  assign l1_int   = ~mode_reg[irq4_pkg::IV1_BIT];

  // Level-1 request line
  logic        dedic;
  logic        edge_sel;
  logic        line_low;
  logic        fall;

  assign dedic    = mode_reg[irq4_pkg::MODE_BIT];
  assign edge_sel = mode_reg[irq4_pkg::ET1_BIT];
  assign line_low = ~REQUEST_LINE_LOW_N;
  assign fall     = line_prev_reg & line_low;

  // Vector forming
  logic        ack_any;
  logic [4:0]  code;
  logic [7:0]  vec_val;

  // A vector is answered in the cycle after the acknowledge; level 4 wins if both arrive
  assign ack_any  = ACK_LEVEL4 | (ACK_LEVEL1 & l1_int);
  assign code     = ACK_LEVEL4 ? code4 : irq4_pkg::L1_CODE;
  assign vec_val  = vec_wr_reg ? {upper, code} : irq4_pkg::UNINIT_VEC;

  always_comb begin
    mode_next = mode_reg;
    if (wr_mode) begin
      // Reserved bits 11 and 4..0 never store
      mode_next = (mode_reg & ~(bmask & irq4_pkg::MODE_WMASK)) |
                  (wbits & irq4_pkg::MODE_WMASK);
    end
  end

  always_comb begin
    mask_next = wr_mask ? ((mask_reg & ~bmask) | wbits) : mask_reg;
  end

  // Per-bit next state; a hardware set wins over a same-cycle software clear
  for (genvar b = 0; b < 16; b++) begin : g_bit
    // Event sources mirror their unmasked event summary instead of latching
    assign pend_next[b] = HAS_EVENT[b] ? evt_lvl[b] :
                          ((pend_reg[b] & ~pend_w1c[b] & ~ack_clr[b]) | src_set[b]);
    // The error source never enters service, so bit 0 stays clear
    assign insv_next[b] = (b == 0) ? 1'b0 : ((insv_reg[b] & ~insv_w1c[b]) | ack_set[b]);
  end

  always_comb begin
    l1_pend_next = l1_pend_reg;
    if (!edge_sel) begin
      l1_pend_next = line_low;
    end else if (fall) begin
      l1_pend_next = 1'b1;
    end else if (ACK_LEVEL1) begin
      l1_pend_next = 1'b0;
    end
  end

  // Software-visible registers
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mode_reg <= irq4_pkg::RST16;
      pend_reg <= irq4_pkg::RST16;
      mask_reg <= irq4_pkg::RST16;
      insv_reg <= irq4_pkg::RST16;
    end else begin
      mode_reg <= mode_next;
      pend_reg <= pend_next;
      mask_reg <= mask_next;
      insv_reg <= insv_next;
    end
  end

  // Vector-written flag and level-1 line state
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      vec_wr_reg    <= 1'b0;
      line_prev_reg <= 1'b0;
      l1_pend_reg   <= 1'b0;
    end else begin
      vec_wr_reg    <= vec_wr_reg | (wr_mode & ws_reg[0]);
      // Prev holds "was high" so a low line seen right after reset is not an edge
      line_prev_reg <= ~line_low;
      l1_pend_reg   <= l1_pend_next;
    end
  end

  // Requests to the core lag the register state by one cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      l4_req_reg <= 1'b0;
      l1_req_reg <= 1'b0;
    end else begin
      l4_req_reg <= fwd;
      l1_req_reg <= dedic & l1_pend_reg;
    end
  end

  // Vector holds its last value; the valid flag is a one-cycle acknowledge
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      vec_reg     <= 8'h00;
      vec_vld_reg <= 1'b0;
    end else begin
      vec_reg     <= ack_any ? vec_val : vec_reg;
      vec_vld_reg <= ack_any;
    end
  end

  // Write address: held until the answer is taken, so a second write waits
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      aw_rdy_reg <= 1'b1;
      wa_reg     <= '0;
    end else if (aw_hs) begin
      aw_rdy_reg <= 1'b0;
      wa_reg     <= AWADDR;
    end else if (b_hs) begin
      aw_rdy_reg <= 1'b1;
    end
  end

  // Write data: address and data may arrive in either order
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      w_rdy_reg <= 1'b1;
      wd_reg    <= irq4_pkg::RST16;
      ws_reg    <= 2'b00;
    end else if (w_hs) begin
      w_rdy_reg <= 1'b0;
      wd_reg    <= WDATA[15:0];
      ws_reg    <= WSTRB[1:0];
    end else if (b_hs) begin
      w_rdy_reg <= 1'b1;
    end
  end

  // Write answer follows both halves; unmapped offsets get an error response
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= irq4_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? irq4_pkg::RESP_OKAY : irq4_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read address: refused while the answer is still out
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end else if (ar_hs) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
    end else if (r_hs) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Read data: upper half of the word always reads zero; held until taken
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= irq4_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rdata_reg <= {16'h0000, rd_val};
      rresp_reg <= rd_hit ? irq4_pkg::RESP_OKAY : irq4_pkg::RESP_SLVERR;
    end
  end

  // Bus outputs
  assign AWREADY      = aw_rdy_reg;
  assign WREADY       = w_rdy_reg;
  assign BVALID       = bvalid_reg;
  assign BRESP        = bresp_reg;
  assign ARREADY      = ar_rdy_reg;
  assign RVALID       = rvalid_reg;
  assign RDATA        = rdata_reg;
  assign RRESP        = rresp_reg;

  // Core-side outputs
  assign LEVEL4_REQ   = l4_req_reg;
  assign LEVEL1_REQ   = l1_req_reg;
  assign VECTOR       = vec_reg;
  assign VECTOR_VALID = vec_vld_reg;

endmodule

// [design/irq4_pkg.sv]
// Constants for the level-4 interrupt pending, mask and in-service block
package irq4_pkg;
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_MODE    = 5'h00;
  localparam logic [4:0]  OFS_PEND    = 5'h04;
  localparam logic [4:0]  OFS_MASK    = 5'h08;
  localparam logic [4:0]  OFS_INSV    = 5'h0c;
  localparam int          MODE_BIT    = 15;
  localparam int          IV1_BIT     = 12;
  localparam int          ET1_BIT     = 8;
  localparam int          VEC_LSB     = 5;
  localparam int          VEC_MSB     = 7;
  localparam logic [15:0] MODE_WMASK  = 16'h91e0;
  localparam logic [15:0] RST16       = 16'h0000;
  localparam logic [15:0] HAS_EVT_DEF = 16'h2d00;
  localparam logic [7:0]  UNINIT_VEC  = 8'h0f;
  localparam logic [4:0]  ERR_CODE    = 5'h00;
  localparam logic [4:0]  L1_CODE     = 5'h11;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// [test/core_model.sv]
// Processor core stand-in that runs interrupt acknowledge cycles
module core_model (
  input  wire logic       CLK_SYS,
  input  wire logic       VECTOR_VALID,
  input  wire logic [7:0] VECTOR,
  output logic            ACK_LEVEL4,
  output logic            ACK_LEVEL1
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ACK_LEVEL4 = 1'b0;
    ACK_LEVEL1 = 1'b0;
  end
  // Delay models a slow core; a lost answer returns unknown so the bench flags it
  task automatic ack(input logic lvl1, input int dly, output logic [7:0] vec);
    int n;
    n = 0;
    vec = 8'hxx;
    repeat (dly) @(posedge CLK_SYS);
    ACK_LEVEL4 <= !lvl1;
    ACK_LEVEL1 <= lvl1;
    @(posedge CLK_SYS);
    ACK_LEVEL4 <= 1'b0;
    ACK_LEVEL1 <= 1'b0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (VECTOR_VALID !== 1'b1 && n < 8);
    if (VECTOR_VALID === 1'b1) vec = VECTOR;
  endtask
endmodule

// [test/irq4_ctrl_asserts.sv]
// Port checker for the level-4 interrupt controller
module irq4_ctrl_asserts (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        ACK_LEVEL4,
  input wire logic        ACK_LEVEL1,
  input wire logic [7:0]  VECTOR,
  input wire logic        VECTOR_VALID
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence both_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence resp_next;
    ##1 BVALID;
  endsequence
  a_write_answer: assert property (both_taken |=> resp_next) else $error("write response late");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("bresp moved");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && RDATA[31:16] == 16'h0) else $error("read");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("rdata moved");
  a_ack_answer: assert property (ACK_LEVEL4 |=> VECTOR_VALID) else $error("no vector after ack");
  a_vector_cause: assert property (VECTOR_VALID |-> $past(ACK_LEVEL4 || ACK_LEVEL1)) else $error("stray vector");
  a_level1_code: assert property (VECTOR_VALID && $past(ACK_LEVEL1 && !ACK_LEVEL4) |->
    VECTOR[4:0] == 5'h11 || VECTOR == 8'h0f) else $error("level one code");
  a_level4_code: assert property (VECTOR_VALID && $past(ACK_LEVEL4) |-> !VECTOR[4]) else $error("level four code");
endmodule
bind irq4_ctrl irq4_ctrl_asserts chk_i (.*);

// [test/irq4_ctrl_bench.sv]
// Self-checking bench for the level-4 interrupt controller
module irq4_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, REQUEST_LINE_LOW_N, ACK_LEVEL4, ACK_LEVEL1;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LEVEL4_REQ, LEVEL1_REQ, VECTOR_VALID;
  logic [4:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, r;
  logic [15:1] INTERNAL_LEVEL4_REQUEST, EVENT_ACTIVE;
  logic [7:0]  VECTOR, v;
  int          fails, compares;
  typedef struct {logic [4:0] a; logic [15:0] w; logic [15:0] e;} row_t;
  row_t rows[4] = '{'{5'h00, 16'hffff, 16'h91e0}, '{5'h04, 16'hffff, 16'h0}, '{5'h0c, 16'hffff, 16'h0},
                    '{5'h08, 16'haaaa, 16'haaaa}};
  irq4_ctrl dut (.*);
  core_model core (.*);
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bready and rready rise only once the answer is seen, so the hold paths get exercised
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    AWADDR <= a;
    WDATA <= {16'h0, w};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        r = BRESP;
        break;
      end
      if (BVALID) BREADY <= 1'b1;
    end
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        d = RDATA;
        r = RRESP;
        break;
      end
      if (RVALID) RREADY <= 1'b1;
    end
    RREADY <= 1'b0;
    chk(d, {16'h0, e});
  endtask
  task automatic pulse(input int i);
    INTERNAL_LEVEL4_REQUEST[i] <= 1'b1;
    @(posedge CLK_SYS);
    INTERNAL_LEVEL4_REQUEST <= '0;
    repeat (2) @(posedge CLK_SYS);
  endtask
  initial begin
    {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, INTERNAL_LEVEL4_REQUEST, EVENT_ACTIVE} = '0;
    WSTRB = 4'h3;
    REQUEST_LINE_LOW_N = 1'b1;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
      chk(32'(r), 32'(irq4_pkg::RESP_OKAY));
    end
    wr(5'h10, 16'hffff);
    chk(32'(r), 32'(irq4_pkg::RESP_SLVERR));
    rd(5'h10, 16'h0);
    chk(32'(r), 32'(irq4_pkg::RESP_SLVERR));
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    for (int a = 0; a < 4; a++) rd(5'(a * 4), 16'h0);
    core.ack(1'b0, 0, v);
    chk(32'(v), 32'h0f);
    rd(5'h04, 16'h0001);
    rd(5'h0c, 16'h0);
    wr(5'h04, 16'h0001);
    rd(5'h04, 16'h0);
    wr(5'h00, 16'h8040);
    wr(5'h08, 16'hffff);
    pulse(9);
    chk(32'(LEVEL4_REQ), 32'h1);
    core.ack(1'b0, 1, v);
    chk(32'(v), 32'h49);
    rd(5'h04, 16'h0);
    rd(5'h0c, 16'h0200);
    pulse(5);
    chk(32'(LEVEL4_REQ), 32'h0);
    rd(5'h04, 16'h0020);
    wr(5'h0c, 16'h0200);
    repeat (2) @(posedge CLK_SYS);
    chk(32'(LEVEL4_REQ), 32'h1);
    wr(5'h08, 16'hffdf);
    repeat (2) @(posedge CLK_SYS);
    chk(32'(LEVEL4_REQ), 32'h0);
    rd(5'h04, 16'h0020);
    core.ack(1'b0, 3, v);
    chk(32'(v), 32'h40);
    wr(5'h08, 16'hffff);
    repeat (2) @(posedge CLK_SYS);
    chk(32'(LEVEL4_REQ), 32'h1);
    core.ack(1'b0, 0, v);
    chk(32'(v), 32'h45);
    EVENT_ACTIVE[13] <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    rd(5'h04, 16'h2001);
    EVENT_ACTIVE <= '0;
    repeat (3) @(posedge CLK_SYS);
    rd(5'h04, 16'h0001);
    REQUEST_LINE_LOW_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    chk(32'(LEVEL1_REQ), 32'h1);
    wr(5'h00, 16'h8140);
    core.ack(1'b1, 0, v);
    chk(32'(v), 32'h51);
    repeat (3) @(posedge CLK_SYS);
    chk(32'(LEVEL1_REQ), 32'h0);
    REQUEST_LINE_LOW_N <= 1'b1;
    @(posedge CLK_SYS);
    REQUEST_LINE_LOW_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    chk(32'(LEVEL1_REQ), 32'h1);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    fails++;
    give_verdict();
  end
endmodule
